// ==== tac_adc_model.sv ====
// Behavioural converter answering the sequencer's convert pulses.
// Assumes the bench holds the next code on code and picks the answer delay with slow.
`timescale 1ns/1ps
module tac_adc_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic convert_start,
  input wire logic slow,
  input wire logic [11:0] code,
  output logic adc_done,
  output logic [11:0] adc_data
);
  // ------
  // Conversion timer
  // ------
  int cnt;
  logic [11:0] held;
  // Outside the done cycle the data lines toggle, so stale data never looks valid
  always_ff @(posedge core_clk) begin
    adc_done <= 1'b0;
    adc_data <= reset ? 12'h000 : ~adc_data;
    if (reset) begin
      cnt <= 0;
    end else if (convert_start) begin
      cnt <= slow ? 9 : 2;
      held <= code;
    end else if (cnt == 1) begin
      cnt <= 0;
      adc_done <= 1'b1;
      adc_data <= held;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== tac_measure_ctrl.sv ====
// Touch ADC measurement configuration registers and the sample/convert/average sequencer.
// Assumes the ADC answers every convert pulse with exactly one done pulse carrying a 12-bit code.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

module tac_measure_ctrl #(
  parameter int MAX_SAMPLES = 16,
  parameter int DATA_W = 12
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic meas_start,
  input wire logic [1:0] meas_axis,
  output logic meas_busy,
  output tac_pkg::tac_adc_ctrl_s adc_ctrl,
  input wire logic adc_done,
  input wire logic [DATA_W-1:0] adc_data,
  output tac_pkg::tac_result_s result
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ACQUIRE, ST_CONVERT, ST_REDUCE} tac_state_e;
  typedef logic [1:0] tac_axis_sel_t;

  logic [7:0] measurement_resolution_cfg;
  logic [7:0] measurement_averaging_cfg;
  logic [7:0] adc_sampling_time_cfg;
  logic [7:0] op_mode_cfg;
  tac_state_e state;
  tac_axis_sel_t run_axis;
  logic [1:0] run_depth;
  logic [11:0] acq_count;
  logic [4:0] sample_idx;
  logic [DATA_W-1:0] sample_mem [MAX_SAMPLES];
  logic [4:0] run_count;
  logic [4:0] keep_lo;
  logic [4:0] keep_hi;
  logic [2:0] keep_shift;
  logic [4:0] rank [MAX_SAMPLES];
  logic [MAX_SAMPLES-1:0] keep;
  logic [DATA_W+4:0] keep_sum;
  logic [DATA_W-1:0] next_result;
  logic low_power_convert;
  logic filter_type_sel;
  logic avg_enable;

  assign low_power_convert = measurement_resolution_cfg[tac_pkg::LOW_POWER_BIT];
  assign filter_type_sel = op_mode_cfg[tac_pkg::FILTER_TYPE_BIT];
  assign avg_enable = op_mode_cfg[tac_pkg::AVG_ENABLE_BIT];

  // ---------------------------------------------------------------------------
  // Field decoding
  // ---------------------------------------------------------------------------
  // Two-bit per-axis field: X in 7:6 down to Z2 in 1:0
  function automatic logic [1:0] axis_field(input logic [7:0] cfg, input logic [1:0] axis);
    logic [1:0] field;
    field = 2'h0;
    unique case (axis)
      2'h0: field = cfg[7:6];
      2'h1: field = cfg[5:4];
      2'h2: field = cfg[3:2];
      2'h3: field = cfg[1:0];
    endcase
    return field;
  endfunction

  // Acquisition window in core cycles for a sampling-time code
  function automatic logic [11:0] acq_cycles(input logic [1:0] code);
    logic [11:0] cyc;
    cyc = tac_pkg::ACQ_CYC_0;
    unique case (code)
      2'h0: cyc = tac_pkg::ACQ_CYC_0;
      2'h1: cyc = tac_pkg::ACQ_CYC_1;
      2'h2: cyc = tac_pkg::ACQ_CYC_2;
      2'h3: cyc = tac_pkg::ACQ_CYC_3;
    endcase
    return cyc;
  endfunction

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // Configuration registers; writes during a run take effect on the next run only for
  // depth and axis, since those are latched at start
  always_ff @(posedge core_clk) begin
    if (reset) begin
      measurement_resolution_cfg <= tac_pkg::RESOLUTION_RST;
      measurement_averaging_cfg <= tac_pkg::AVERAGING_RST;
      adc_sampling_time_cfg <= tac_pkg::SAMPLING_RST;
      op_mode_cfg <= tac_pkg::OP_MODE_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        tac_pkg::ADDR_RESOLUTION: measurement_resolution_cfg <= {3'h0, reg_wdata[4:0]};
        tac_pkg::ADDR_AVERAGING: measurement_averaging_cfg <= reg_wdata;
        tac_pkg::ADDR_SAMPLING: adc_sampling_time_cfg <= reg_wdata;
        tac_pkg::ADDR_OP_MODE: op_mode_cfg <= {6'h00, reg_wdata[1:0]};
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------------------
  // Read data is registered so it stands only in the cycle after the strobe;
  // unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        tac_pkg::ADDR_RESOLUTION: reg_rdata <= measurement_resolution_cfg;
        tac_pkg::ADDR_AVERAGING: reg_rdata <= measurement_averaging_cfg;
        tac_pkg::ADDR_SAMPLING: reg_rdata <= adc_sampling_time_cfg;
        tac_pkg::ADDR_OP_MODE: reg_rdata <= op_mode_cfg;
        tac_pkg::ADDR_STATUS: reg_rdata <= {4'h0, result.axis, result.valid, meas_busy};
        tac_pkg::ADDR_RESULT_HI: reg_rdata <= {4'h0, result.data[11:8]};
        tac_pkg::ADDR_RESULT_LO: reg_rdata <= result.data[7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // Acquire, convert, repeat until the depth is reached, then reduce
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      run_axis <= 2'h0;
      run_depth <= 2'h0;
      acq_count <= 12'h000;
      sample_idx <= 5'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (meas_start) begin
            run_axis <= meas_axis;
            // Averaging disabled by the mode register forces a single sample
            run_depth <= avg_enable ? axis_field(measurement_averaging_cfg, meas_axis) : 2'h0;
            acq_count <= acq_cycles(axis_field(adc_sampling_time_cfg, meas_axis));
            sample_idx <= 5'h00;
            state <= ST_ACQUIRE;
          end
        end
        ST_ACQUIRE: begin
          // Conversion is only requested once the full window has elapsed
          if (acq_count == 12'h001) begin
            state <= ST_CONVERT;
          end
          acq_count <= acq_count - 12'h001;
        end
        ST_CONVERT: begin
          if (adc_done) begin
            if (sample_idx == run_count - 5'h01) begin
              state <= ST_REDUCE;
            end else begin
              // Next sample starts a fresh window, so spacing is window plus conversion
              sample_idx <= sample_idx + 5'h01;
              acq_count <= acq_cycles(axis_field(adc_sampling_time_cfg, run_axis));
              state <= ST_ACQUIRE;
            end
          end
        end
        ST_REDUCE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture each conversion into the sample store
  always_ff @(posedge core_clk) begin
    if (state == ST_CONVERT && adc_done) begin
      sample_mem[sample_idx[3:0]] <= adc_data;
    end
  end

  // ---------------------------------------------------------------------------
  // ADC control outputs
  // ---------------------------------------------------------------------------
  // Registered so the ADC sees clean levels; convert pulses once per window end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      adc_ctrl <= '0;
    end else begin
      adc_ctrl.sample_en <= (state == ST_ACQUIRE) && (acq_count != 12'h001);
      adc_ctrl.convert_start <= (state == ST_ACQUIRE) && (acq_count == 12'h001);
      adc_ctrl.low_power_convert <= low_power_convert;
      adc_ctrl.res_8bit <= measurement_resolution_cfg[tac_pkg::RES_FIELD_MSB - run_axis];
    end
  end

  assign meas_busy = (state != ST_IDLE);

  // ---------------------------------------------------------------------------
  // Filter setup
  // ---------------------------------------------------------------------------
  // Depth code d takes 1 or 2^(d+1) samples; median keeps the centre half
  always_comb begin
    run_count = (run_depth == 2'h0) ? 5'h01 : 5'(5'h02 << run_depth);
    if (filter_type_sel || run_depth == 2'h0) begin
      keep_lo = 5'h00;
      keep_hi = run_count;
      // Widen before the add so depth code 3 gives a shift of 4, not a wrapped 0
      keep_shift = (run_depth == 2'h0) ? 3'h0 : (3'(run_depth) + 3'h1);
    end else begin
      keep_lo = run_count >> 2;
      keep_hi = run_count - (run_count >> 2);
      keep_shift = 3'(run_depth);
    end
  end

  // ---------------------------------------------------------------------------
  // Ranking
  // ---------------------------------------------------------------------------
  // Each sample's rank counts smaller samples, ties broken by index, so ranks are unique
  for (genvar g = 0; g < MAX_SAMPLES; g++) begin : g_rank
    always_comb begin
      rank[g] = 5'h00;
      for (int j = 0; j < MAX_SAMPLES; j++) begin
        if (5'(j) < run_count && j != g) begin
          if (sample_mem[j] < sample_mem[g] || (sample_mem[j] == sample_mem[g] && j < g)) begin
            rank[g] = rank[g] + 5'h01;
          end
        end
      end
      keep[g] = (5'(g) < run_count) && (rank[g] >= keep_lo) && (rank[g] < keep_hi);
    end
  end

  // Sum of the kept samples; kept count is a power of two so the mean is a shift
  always_comb begin
    keep_sum = '0;
    for (int i = 0; i < MAX_SAMPLES; i++) begin
      if (keep[i]) begin
        keep_sum = keep_sum + (DATA_W+5)'(sample_mem[i]);
      end
    end
    next_result = DATA_W'(keep_sum >> keep_shift);
  end

  // ---------------------------------------------------------------------------
  // Result
  // ---------------------------------------------------------------------------
  // Valid is a one-cycle pulse; data and axis hold until the next run ends
  always_ff @(posedge core_clk) begin
    if (reset) begin
      result <= '0;
    end else begin
      result.valid <= (state == ST_REDUCE);
      if (state == ST_REDUCE) begin
        result.data <= next_result;
        result.axis <= tac_pkg::tac_axis_e'(run_axis);
      end
    end
  end

endmodule

// ==== tac_measure_ctrl_assertions.sv ====
// Concurrent checks on the sequencer's ports.
// Assumes one clock domain and binding to every instance of the sequencer.
`timescale 1ns/1ps
module tac_measure_ctrl_assertions #(
  parameter int MAX_SAMPLES = 16,
  parameter int DATA_W = 12
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic meas_start,
  input wire logic meas_busy,
  input wire tac_pkg::tac_adc_ctrl_s adc_ctrl,
  input wire logic adc_done,
  input wire tac_pkg::tac_result_s result
);
  // ------
  // Window lengths and helper counter
  // ------
  // Oscillator periods of 500 ns at 40 ns core cycles; one cycle goes to the state change
  localparam int W0 = 4 * 500 / 40 - 1;
  localparam int W1 = 16 * 500 / 40 - 1;
  localparam int W2 = 64 * 500 / 40 - 1;
  localparam int W3 = 256 * 500 / 40 - 1;
  int win;
  // Length of the current sampling window
  always_ff @(posedge core_clk) begin
    win <= (reset || !adc_ctrl.sample_en) ? 0 : win + 1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_accept;
    meas_start && !meas_busy;
  endsequence
  sequence s_window;
    meas_busy ##1 adc_ctrl.sample_en;
  endsequence
  a_window_start: assert property (s_accept |=> s_window) else $error("no sampling window after start");
  a_window_length: assert property (adc_ctrl.convert_start |-> win inside {W0, W1, W2, W3})
    else $error("sampling window has wrong length");
  a_convert_after: assert property (adc_ctrl.convert_start |-> !adc_ctrl.sample_en && $past(adc_ctrl.sample_en))
    else $error("conversion not right after window");
  a_convert_pulse: assert property (adc_ctrl.convert_start |=> !adc_ctrl.convert_start)
    else $error("convert pulse too long");
  a_sample_busy: assert property (adc_ctrl.sample_en |-> meas_busy) else $error("sampling while idle");
  a_result_done: assert property (result.valid |-> $past(adc_done, 2) && !meas_busy)
    else $error("result not two cycles after done");
  a_result_pulse: assert property (result.valid |=> !result.valid) else $error("result pulse too long");
  a_lowpower_copy: assert property (reg_wr && reg_addr == tac_pkg::ADDR_RESOLUTION |->
    ##2 adc_ctrl.low_power_convert == $past(reg_wdata[tac_pkg::LOW_POWER_BIT], 2)) else $error("power mode not applied");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read cycle");
endmodule

// ==== tac_measure_ctrl_tb.sv ====
// Self-checking bench: register port, sampling windows, sample counts and averaging.
// Assumes the converter model answers each convert pulse; the checker is bound at the foot.
`timescale 1ns/1ps
module tac_measure_ctrl_tb;
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, meas_start = 1'b0, slow = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, q, v, op, res;
  logic [1:0] meas_axis = 2'h0;
  logic meas_busy, adc_done;
  logic [11:0] adc_data;
  logic [11:0] samp [16];
  logic [15:0] rnd = 16'h004E;
  int sidx = 0, mismatches = 0, total_checks = 0;
  tac_pkg::tac_adc_ctrl_s adc_ctrl;
  tac_pkg::tac_result_s result;
  // ------
  // Clock, design and converter
  // ------
  always #20 core_clk = ~core_clk;
  // Bench-side index of the code the converter hands out next
  always @(posedge core_clk) if (adc_ctrl.convert_start === 1'b1) sidx <= sidx + 1;
  tac_measure_ctrl i_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_start(meas_start), .meas_axis(meas_axis),
    .meas_busy(meas_busy), .adc_ctrl(adc_ctrl), .adc_done(adc_done), .adc_data(adc_data), .result(result));
  tac_adc_model i_adc (.core_clk(core_clk), .reset(reset), .convert_start(adc_ctrl.convert_start), .slow(slow),
    .code(samp[sidx[3:0]]), .adc_done(adc_done), .adc_data(adc_data));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Median ranks the codes and keeps the middle half; plain keeps all; truncating mean
  function automatic logic [11:0] expect_avg(input int n, input logic median);
    logic [11:0] s [16];
    int lo, sum;
    s = samp;
    for (int a = 0; a < n; a++)
      for (int b = 0; b + 1 < n - a; b++)
        if (median && s[b] > s[b + 1]) {s[b], s[b + 1]} = {s[b + 1], s[b]};
    lo = median ? n / 4 : 0;
    sum = 0;
    for (int a = lo; a < n - lo; a++) sum += s[a];
    return 12'(sum / (n - 2 * lo));
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bus cycles leave one idle edge so no strobe is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic chk_zero();
    for (int a = 2; a < 6; a++) begin
      rd(a == 5 ? 8'h07 : 8'(a), q);
      check(q, 16'h0000);
    end
  endtask
  // One measurement with a refused second start in mid-run
  task automatic measure(input logic [1:0] ax, input int n, input logic median, input int tc, input logic r8);
    int k, hi;
    sidx <= 0;
    meas_axis <= ax;
    meas_start <= 1'b1;
    hi = 0;
    @(posedge core_clk);
    meas_start <= 1'b0;
    for (k = 0; k < 60000; k++) begin
      if (k == 3) meas_start <= 1'b1;
      if (k == 4) meas_start <= 1'b0;
      @(posedge core_clk);
      #1;
      hi = adc_ctrl.sample_en === 1'b1 ? hi + 1 : hi;
      if (adc_ctrl.convert_start === 1'b1) begin
        check(16'(hi), 16'((4 << (2 * tc)) * 500 / 40 - 1));
        check(adc_ctrl.res_8bit, r8);
        hi = 0;
      end
      if (result.valid === 1'b1) break;
    end
    if (k == 60000) begin
      mismatches++;
      stop_test();
    end
    check(result.data, expect_avg(n, median));
    check(result.axis, ax);
    check(meas_busy, 1'b0);
    check(16'(sidx), 16'(n));
    @(posedge core_clk);
    rd(tac_pkg::ADDR_RESULT_LO, q);
    check(q, 16'(expect_avg(n, median) & 12'h0FF));
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    int d, ax, sh, n, tc;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    chk_zero();
    for (int i = 0; i < 16; i++) begin
      d = i >> 2;
      ax = i % 4;
      sh = 6 - 2 * ax;
      op = (i % 5 == 4) ? 8'h01 : {7'h01, i[0]};
      n = op[1] ? (d == 0 ? 1 : 2 << d) : 1;
      tc = (d == 3) ? i % 2 : i % 4;
      slow <= i[1];
      rnd = lfsr(rnd);
      res = rnd[7:0];
      wr(tac_pkg::ADDR_RESOLUTION, res);
      rd(tac_pkg::ADDR_RESOLUTION, q);
      check(q, res & 8'h1F);
      check(adc_ctrl.low_power_convert, res[4]);
      for (int r = 0; r < 2; r++) begin
        rnd = lfsr(rnd);
        v = (rnd[7:0] & ~(8'h03 << sh)) | 8'((r == 1 ? tc : d) << sh);
        wr(8'(tac_pkg::ADDR_AVERAGING + r), v);
        rd(8'(tac_pkg::ADDR_AVERAGING + r), q);
        check(q, v);
      end
      wr(tac_pkg::ADDR_OP_MODE, op);
      for (int j = 0; j < 16; j++) begin
        rnd = lfsr(rnd);
        samp[j] <= rnd[11:0];
      end
      measure(2'(ax), n, !op[0], tc, res[3 - ax]);
    end
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    chk_zero();
    stop_test();
  end
endmodule
bind tac_measure_ctrl tac_measure_ctrl_assertions #(.MAX_SAMPLES(MAX_SAMPLES), .DATA_W(DATA_W)) i_chk (
  .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_start(meas_start), .meas_busy(meas_busy),
  .adc_ctrl(adc_ctrl), .adc_done(adc_done), .result(result));

// ==== tac_pkg.sv ====
// Package for the touch ADC measurement configuration and sequencing block.
// Assumes a 25 MHz core clock and a single register port of byte-wide data.
package tac_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_RESOLUTION = 8'h02;
  localparam logic [7:0] ADDR_AVERAGING = 8'h03;
  localparam logic [7:0] ADDR_SAMPLING = 8'h04;
  localparam logic [7:0] ADDR_OP_MODE = 8'h0B;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_RESULT_HI = 8'h11;
  localparam logic [7:0] ADDR_RESULT_LO = 8'h12;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int LOW_POWER_BIT = 4;
  localparam int RES_FIELD_MSB = 3;
  localparam int FILTER_TYPE_BIT = 0;
  localparam int AVG_ENABLE_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_VALID_BIT = 1;
  localparam int STATUS_AXIS_LSB = 2;
  localparam logic [7:0] RESOLUTION_RST = 8'h00;
  localparam logic [7:0] AVERAGING_RST = 8'h00;
  localparam logic [7:0] SAMPLING_RST = 8'h00;
  localparam logic [7:0] OP_MODE_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing: acquisition windows in periods of the 2 MHz oscillator
  // ---------------------------------------------------------------------------
  localparam int OSC_PERIOD_NS = 500;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACQ_PERIODS_0 = 4;
  localparam int ACQ_PERIODS_1 = 16;
  localparam int ACQ_PERIODS_2 = 64;
  localparam int ACQ_PERIODS_3 = 256;
  // Least times, so round up to whole core cycles
  localparam logic [11:0] ACQ_CYC_0 = 12'((ACQ_PERIODS_0 * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ACQ_CYC_1 = 12'((ACQ_PERIODS_1 * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ACQ_CYC_2 = 12'((ACQ_PERIODS_2 * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ACQ_CYC_3 = 12'((ACQ_PERIODS_3 * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {AXIS_X, AXIS_Y, AXIS_Z1, AXIS_Z2} tac_axis_e;

  typedef struct packed {
    logic sample_en;
    logic convert_start;
    logic low_power_convert;
    logic res_8bit;
  } tac_adc_ctrl_s;

  typedef struct packed {
    logic valid;
    tac_axis_e axis;
    logic [11:0] data;
  } tac_result_s;

endpackage

// ==== tac_types_note.sv ====
// unused
